// [inc/fbp_pkg.sv]
// Package of constants and carrier types for the flash erase and protection block.
package fbp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  localparam int unsigned FLASH_BYTES  = 65536;
  localparam int unsigned WORD_BYTES   = 4;
  localparam int unsigned WORDS        = FLASH_BYTES / WORD_BYTES;
  localparam int unsigned ADDR_W       = 14;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ERASE_BYTES  = 1024;
  localparam int unsigned ERASE_WORDS  = ERASE_BYTES / WORD_BYTES;
  localparam int unsigned OFFS_W       = 8;
  localparam int unsigned BLOCKS       = FLASH_BYTES / ERASE_BYTES;
  localparam int unsigned BLOCK_W      = 6;
  localparam int unsigned REGIONS      = BLOCKS / 2;
  localparam int unsigned REGION_LSB   = 1;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] DENY_WORD   = 32'h00000000;
  localparam logic [OFFS_W-1:0] OFFS_LAST   = 8'hFF;
  localparam logic [REGIONS-1:0] PROT_RESET = 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    FBP_IDLE  = 2'b00,
    FBP_ERASE = 2'b01,
    FBP_DONE  = 2'b11
  } fbp_state_type;

  typedef enum logic [1:0] {
    FBP_SRC_FETCH = 2'b00,
    FBP_SRC_DATA  = 2'b01,
    FBP_SRC_DEBUG = 2'b10
  } fbp_src_type;

  typedef struct packed {
    logic              valid;
    fbp_src_type       src;
    logic [ADDR_W-1:0] addr;
  } fbp_rd_req_type;

  typedef struct packed {
    logic              valid;
    logic              deny;
    logic [DATA_W-1:0] data;
  } fbp_rd_rsp_type;

  typedef struct packed {
    logic              prog;
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbp_wr_req_type;

  typedef struct packed {
    logic done;
    logic refused;
    logic busy;
  } fbp_wr_rsp_type;

endpackage : fbp_pkg

// [src/fbp_array.sv]
// Word-wide flash storage array with registered read data.
`timescale 1ns/10ps
`default_nettype none
module fbp_array #(
  parameter int unsigned DEPTH  = 16384,
  parameter int unsigned AW     = 14,
  parameter int unsigned DW     = 32
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : fbp_array
`default_nettype wire

// [src/fbp_flash_protect.sv]
// Flash access control, block erase and program logic with per-region protection.
// Contract
// RL1 - The block holds a 64 KB flash array reached through it for reads, programming and erase.
// RL2 - The flash is split into 1 KB erase blocks, each erased on its own.
// RL3 - Erasing a block sets every bit in it to one.
// RL4 - Protection works on 2 KB regions of paired blocks, each markable read-only or execute-only.
// RL5 - Program and erase requests to a read-only region are refused.
// RL6 - Program and erase requests to an execute-only region are refused.
// RL7 - Execute-only regions may be read only by instruction fetches, not by data reads or debugger.
// RL8 - A refused access leaves the flash unchanged and a refused read returns no stored data.
`timescale 1ns/10ps
`default_nettype none
module fbp_flash_protect
  import fbp_pkg::*;
(
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  // Protection marks, one bit per 2 KB region
  input  wire logic [fbp_pkg::REGIONS-1:0] RO_MARK,
  input  wire logic [fbp_pkg::REGIONS-1:0] XO_MARK,
  // Read port
  input  wire fbp_pkg::fbp_rd_req_type     RD_REQ,
  output var  fbp_pkg::fbp_rd_rsp_type     RD_RSP,
  // Program and erase port
  input  wire fbp_pkg::fbp_wr_req_type     WR_REQ,
  output var  fbp_pkg::fbp_wr_rsp_type     WR_RSP
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    fbp_state_type        state;
    logic [BLOCK_W-1:0]   blk;
    logic [OFFS_W-1:0]    offs;
    logic                 rd_pend;
    logic                 rd_deny;
    logic [REGIONS-1:0]   ro;
    logic [REGIONS-1:0]   xo;
    fbp_rd_rsp_type       rd_rsp;
    fbp_wr_rsp_type       wr_rsp;
  } fbp_regs_type;

  fbp_regs_type      r;
  fbp_regs_type      next_r;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;

  // Marks are sampled once per cycle so a check and its effect see one value.
  function automatic logic region_locked(input logic [ADDR_W-1:0] a,
                                         input logic [REGIONS-1:0] ro,
                                         input logic [REGIONS-1:0] xo);
    logic [BLOCK_W-2:0] reg_idx;
    reg_idx = a[ADDR_W-1 -: BLOCK_W-1]; // RL4
    return ro[reg_idx] | xo[reg_idx]; // RL5 RL6
  endfunction : region_locked

  //////////////////////////////////////////////////////////////////////////////
  fbp_array #(
    .DEPTH (WORDS),
    .AW    (ADDR_W),
    .DW    (DATA_W)
  ) u_array (
    .clk   (CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (RD_REQ.addr),
    .rdata (mem_rdata)
  ); // RL1

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [BLOCK_W-2:0] rreg;
    rreg      = RD_REQ.addr[ADDR_W-1 -: BLOCK_W-1];
    next_r    = r;
    mem_we    = 1'b0;
    mem_waddr = WR_REQ.addr;
    mem_wdata = WR_REQ.data;
    next_r.ro = RO_MARK;
    next_r.xo = XO_MARK;
    next_r.wr_rsp.done    = 1'b0;
    next_r.wr_rsp.refused = 1'b0;
    next_r.rd_rsp.valid   = r.rd_pend;
    next_r.rd_rsp.deny    = r.rd_deny;
    next_r.rd_rsp.data    = r.rd_deny ? DENY_WORD : mem_rdata; // RL8
    next_r.rd_pend = RD_REQ.valid;
    next_r.rd_deny = RD_REQ.valid & r.xo[rreg] & (RD_REQ.src != FBP_SRC_FETCH); // RL7
    case (r.state)
      FBP_IDLE: begin
        if (WR_REQ.erase || WR_REQ.prog) begin
          if (region_locked(WR_REQ.addr, r.ro, r.xo)) begin
            next_r.wr_rsp.refused = 1'b1; // RL5 RL6 RL8
            next_r.wr_rsp.done    = 1'b1;
          end else if (WR_REQ.erase) begin
            next_r.blk   = WR_REQ.addr[ADDR_W-1 -: BLOCK_W]; // RL2
            next_r.offs  = '0;
            next_r.state = FBP_ERASE;
            next_r.wr_rsp.busy = 1'b1;
          end else begin
            mem_we = 1'b1;
            next_r.wr_rsp.done = 1'b1;
          end
        end
      end
      FBP_ERASE: begin
        // One word per cycle keeps the array to a single write port at the cost of 256 cycles.
        mem_we    = 1'b1;
        mem_waddr = {r.blk, r.offs}; // RL2
        mem_wdata = ERASED_WORD; // RL3
        next_r.offs = r.offs + 8'h01;
        if (r.offs == OFFS_LAST) begin
          next_r.state = FBP_DONE;
        end
      end
      FBP_DONE: begin
        next_r.state = FBP_IDLE;
        next_r.wr_rsp.busy = 1'b0;
        next_r.wr_rsp.done = 1'b1;
      end
      default: begin
        next_r.state = FBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r.state   <= FBP_IDLE;
      r.blk     <= '0;
      r.offs    <= '0;
      r.rd_pend <= 1'b0;
      r.rd_deny <= 1'b0;
      r.ro      <= PROT_RESET;
      r.xo      <= PROT_RESET;
      r.rd_rsp  <= '0;
      r.wr_rsp  <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign RD_RSP = r.rd_rsp;
  assign WR_RSP = r.wr_rsp;

endmodule : fbp_flash_protect
`default_nettype wire

// [testbench/fbp_checker.sv]
// Port assertions for the flash protection block.
`timescale 1ns/10ps
`default_nettype none
module fbp_checker
  import fbp_pkg::*;
(
  input wire logic                    CLK,
  input wire logic                    RST_N,
  input wire logic [REGIONS-1:0]      RO_MARK,
  input wire logic [REGIONS-1:0]      XO_MARK,
  input wire fbp_pkg::fbp_rd_req_type RD_REQ,
  input wire fbp_pkg::fbp_rd_rsp_type RD_RSP,
  input wire fbp_pkg::fbp_wr_req_type WR_REQ,
  input wire fbp_pkg::fbp_wr_rsp_type WR_RSP
);
  // Marks count one edge late and read as zero straight after reset.
  logic [REGIONS-1:0] ro;
  logic [REGIONS-1:0] xo;
  always_ff @(posedge CLK) begin
    ro <= RST_N ? RO_MARK : '0;
    xo <= RST_N ? XO_MARK : '0;
  end
  wire logic go = (WR_REQ.prog | WR_REQ.erase) & !WR_RSP.busy;
  wire logic wl = ro[WR_REQ.addr[13:9]] | xo[WR_REQ.addr[13:9]];
  wire logic rx = xo[RD_REQ.addr[13:9]] & (RD_REQ.src != FBP_SRC_FETCH);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence erase_run;
    WR_RSP.busy ##256 WR_RSP.busy ##1 (WR_RSP.done && !WR_RSP.busy);
  endsequence
  rd_lat_a: assert property (RD_REQ.valid |-> ##2 RD_RSP.valid) else $error("late");
  xo_deny_a: assert property (
    RD_REQ.valid && rx |-> ##2 RD_RSP.deny && RD_RSP.data == DENY_WORD) else $error("leak");
  rd_open_a: assert property (RD_REQ.valid && !rx |-> ##2 !RD_RSP.deny) else $error("deny");
  prog_done_a: assert property (go && !WR_REQ.erase |=> WR_RSP.done) else $error("idle");
  lock_ref_a: assert property (
    go && wl |=> WR_RSP.done && WR_RSP.refused && !WR_RSP.busy) else $error("locked");
  open_wr_a: assert property (go && !wl |=> !WR_RSP.refused) else $error("refused");
  blk_erase_a: assert property (go && WR_REQ.erase && !wl |=> erase_run) else $error("erase");
  ref_done_a: assert property (WR_RSP.refused |-> WR_RSP.done) else $error("lone");
endmodule : fbp_checker
`default_nettype wire

// [testbench/fbp_host.sv]
// Processor and debugger request model.
`timescale 1ns/10ps
`default_nettype none
module fbp_host
  import fbp_pkg::*;
(
  input  wire logic                    CLK,
  output var  fbp_pkg::fbp_rd_req_type RD_REQ,
  input  wire fbp_pkg::fbp_rd_rsp_type RD_RSP,
  output var  fbp_pkg::fbp_wr_req_type WR_REQ,
  input  wire fbp_pkg::fbp_wr_rsp_type WR_RSP
);
  initial RD_REQ = '0;
  initial WR_REQ = '0;
  task automatic rd(input fbp_src_type s, input logic [13:0] a, output fbp_rd_rsp_type r);
    @(posedge CLK) RD_REQ <= '{1'b1, s, a};
    @(posedge CLK) RD_REQ.valid <= 1'b0;
    // The answer stands for one cycle only, the one after the array read.
    @(posedge CLK) #1 r = RD_RSP;
  endtask : rd
  task automatic wr(input logic e, input logic [13:0] a, input logic [31:0] d,
                    output fbp_wr_rsp_type r);
    @(posedge CLK) WR_REQ <= '{!e, e, a, d};
    @(posedge CLK) WR_REQ <= '0;
    // A program or refusal answers right after the take edge, so look there first.
    #1 r = WR_RSP;
    repeat (300) begin
      if (r.done) break;
      @(posedge CLK) #1 r = WR_RSP;
    end
  endtask : wr
endmodule : fbp_host
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the flash protection block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fbp_pkg::*;
  logic               CLK;
  logic               RST_N;
  logic [REGIONS-1:0] RO_MARK;
  logic [REGIONS-1:0] XO_MARK;
  fbp_rd_req_type     RD_REQ;
  fbp_rd_rsp_type     RD_RSP;
  fbp_wr_req_type     WR_REQ;
  fbp_wr_rsp_type     WR_RSP;
  fbp_rd_rsp_type     q;
  fbp_wr_rsp_type     w;
  int                 err_total = 0;
  int                 num_checks = 0;
  fbp_flash_protect u_fbp_flash_protect (.CLK(CLK), .RST_N(RST_N), .RO_MARK(RO_MARK),
    .XO_MARK(XO_MARK), .RD_REQ(RD_REQ), .RD_RSP(RD_RSP), .WR_REQ(WR_REQ), .WR_RSP(WR_RSP));
  fbp_host u_fbp_host (.CLK(CLK), .RD_REQ(RD_REQ), .RD_RSP(RD_RSP), .WR_REQ(WR_REQ),
    .WR_RSP(WR_RSP));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic t_erase;
    u_fbp_host.wr(1'b0, 14'h0103, 32'hA5A55A5A, w);
    chk("prog", 32'h2, {w.done, w.refused});
    u_fbp_host.rd(FBP_SRC_DATA, 14'h0103, q);
    chk("word", 32'hA5A55A5A, q.data);
    u_fbp_host.wr(1'b1, 14'h01FF, 32'h0, w);
    chk("erase", 32'h2, {w.done, w.refused});
    u_fbp_host.rd(FBP_SRC_DEBUG, 14'h0103, q);
    chk("erased", ERASED_WORD, q.data);
  endtask : t_erase
  // The mark lands one edge before the request so the lock is already live.
  task automatic t_lock(input logic x, input logic [13:0] a);
    u_fbp_host.wr(1'b0, a, 32'hC3C3C3C3, w);
    chk("open prog", 32'h2, {w.done, w.refused});
    @(posedge CLK);
    RO_MARK[a[13:9]] <= !x;
    XO_MARK[a[13:9]] <= x;
    u_fbp_host.wr(1'b0, a, 32'h0, w);
    chk("lock prog", 32'h3, {w.done, w.refused});
    u_fbp_host.wr(1'b1, a, 32'h0, w);
    chk("lock erase", 32'h3, {w.done, w.refused});
    u_fbp_host.rd(FBP_SRC_FETCH, a, q);
    chk("fetch", 32'hC3C3C3C3, q.data);
    chk("fetch valid", 32'h1, {31'h0, q.valid});
    u_fbp_host.rd(FBP_SRC_DATA, a, q);
    chk("data", x ? DENY_WORD : 32'hC3C3C3C3, q.data);
    u_fbp_host.rd(FBP_SRC_DEBUG, a, q);
    chk("debug", {31'h0, x}, {31'h0, q.deny});
    chk("debug data", x ? DENY_WORD : 32'hC3C3C3C3, q.data);
  endtask : t_lock
  initial begin
    RST_N = 1'b0;
    RO_MARK = '0;
    XO_MARK = '0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    t_erase();
    t_lock(1'b0, 14'h0400);
    t_lock(1'b1, 14'h0600);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge CLK);
    err_total++;
    finish_test();
  end
endmodule : tb_top
bind fbp_flash_protect fbp_checker u_fbp_checker (.CLK(CLK), .RST_N(RST_N), .RO_MARK(RO_MARK),
  .XO_MARK(XO_MARK), .RD_REQ(RD_REQ), .RD_RSP(RD_RSP), .WR_REQ(WR_REQ), .WR_RSP(WR_RSP));
`default_nettype wire
